/* File: logic/agu_defines.vh */
// Constants for the data space address generation block
`ifndef AGU_DEFINES_VH
`define AGU_DEFINES_VH

// ----------------------------------------
// Data width and memory map
// ----------------------------------------
`define DATA_W          16
`define ADDR_W          16
`define SFR_TOP         16'h07FF
`define RAM_BASE        16'h0800
`define NEAR_TOP        16'h1FFF
`define NEAR_FIELD_W    13
`define Y_BASE_DEF      16'h0C00
`define RAM_END_DEF     16'h0FFF

// ----------------------------------------
// Addressing modes
// ----------------------------------------
`define AM_DIRECT       3'h0
`define AM_INDIRECT     3'h1
`define AM_POST_INC     3'h2
`define AM_POST_DEC     3'h3
`define AM_PRE_INC      3'h4
`define AM_PRE_DEC      3'h5
`define AM_NEAR         3'h6
`define AM_BITREV       3'h7

// ----------------------------------------
// Instruction cycle phases
// ----------------------------------------
`define PH_READ         2'h0
`define PH_EXEC         2'h1
`define PH_WRITE        2'h2
`define PH_LAST         2'h3

`define STEP_WORD       16'h0002

`endif

/* File: logic/ea_calc.v */
// Effective address calculator shared by all address units
`timescale 1ns/1ns
`include "agu_defines.vh"

module ea_calc (
    input  wire [2:0]  mode_i,      // Addressing mode
    input  wire [15:0] ptr_i,       // Pointer register value
    input  wire [15:0] lit_i,       // Absolute address or bit-reverse modifier
    input  wire        circ_en_i,   // Circular buffer enable
    input  wire        bitrev_ok_i, // Bit-reversed mode allowed
    input  wire [15:0] circ_lo_i,   // Circular buffer start
    input  wire [15:0] circ_hi_i,   // Circular buffer end
    output reg  [15:0] ea_o,        // Effective address
    output reg  [15:0] ptr_next_o   // Updated pointer value
);

    // ----------------------------------------
    // Circular wrap
    // ----------------------------------------
    function [15:0] wrap;
        input [15:0] a;
        input        en;
        input [15:0] lo;
        input [15:0] hi;
        begin
            if (en && a > hi)
                wrap = lo;
            else if (en && a < lo)
                wrap = {hi[15:1], 1'b0};
            else
                wrap = a;
        end
    endfunction

    // Reverse carry add, used for FFT style buffers
    function [15:0] rev_add;
        input [15:0] a;
        input [15:0] m;
        integer i;
        reg [15:0] ra;
        reg [15:0] rm;
        reg [15:0] s;
        begin
            for (i = 0; i < 16; i = i + 1) begin
                ra[i] = a[15 - i];
                rm[i] = m[15 - i];
            end
            s = ra + rm;
            for (i = 0; i < 16; i = i + 1)
                rev_add[i] = s[15 - i];
        end
    endfunction

    always @* begin
        ea_o       = ptr_i;
        ptr_next_o = ptr_i;
        case (mode_i)
            `AM_DIRECT: begin
                ea_o = lit_i;
            end
            `AM_NEAR: begin
                ea_o = {3'h0, lit_i[`NEAR_FIELD_W-1:0]};
            end
            `AM_INDIRECT: begin
                ea_o = ptr_i;
            end
            `AM_POST_INC: begin
                ptr_next_o = wrap(ptr_i + `STEP_WORD, circ_en_i, circ_lo_i, circ_hi_i);
            end
            `AM_POST_DEC: begin
                ptr_next_o = wrap(ptr_i - `STEP_WORD, circ_en_i, circ_lo_i, circ_hi_i);
            end
            `AM_PRE_INC: begin
                ea_o       = wrap(ptr_i + `STEP_WORD, circ_en_i, circ_lo_i, circ_hi_i);
                ptr_next_o = ea_o;
            end
            `AM_PRE_DEC: begin
                ea_o       = wrap(ptr_i - `STEP_WORD, circ_en_i, circ_lo_i, circ_hi_i);
                ptr_next_o = ea_o;
            end
            `AM_BITREV: begin
                if (bitrev_ok_i)
                    ptr_next_o = rev_add(ptr_i, lit_i);
                else
                    ptr_next_o = ptr_i + `STEP_WORD;
            end
            default: begin
                ea_o = ptr_i;
            end
        endcase
    end

endmodule

/* File: logic/space_decode.v */
// Classifies an effective address into data space regions
`timescale 1ns/1ns
`include "agu_defines.vh"

module space_decode #(
    parameter [15:0] Y_BASE  = `Y_BASE_DEF,
    parameter [15:0] RAM_END = `RAM_END_DEF
) (
    input  wire [15:0] ea_i,      // Address to classify
    output wire        is_sfr_o,  // Special register space
    output wire        is_x_o,    // Implemented X memory
    output wire        is_y_o,    // Implemented Y memory
    output wire        is_near_o, // Inside near region
    output wire        unimpl_o   // Beyond physical memory
);

    assign is_sfr_o  = ea_i <= `SFR_TOP;
    assign is_x_o    = ea_i >= `RAM_BASE && ea_i < Y_BASE;
    assign is_y_o    = ea_i >= Y_BASE && ea_i <= RAM_END;
    assign is_near_o = ea_i <= `NEAR_TOP;
    assign unimpl_o  = ea_i > RAM_END;

endmodule

/* File: logic/data_space_agu.v */
// Data space address generation with X read, X write and Y read units
`timescale 1ns/1ns
`include "agu_defines.vh"

module data_space_agu #(
    parameter [15:0] Y_BASE  = `Y_BASE_DEF,
    parameter [15:0] RAM_END = `RAM_END_DEF
) (
    input  wire        mclk_i,          // 25 MHz core clock
    input  wire        nrst_i,          // Synchronous reset, active low
    input  wire        cycle_start_i,   // Pulse opening an instruction cycle
    input  wire        pf_valid_i,      // Prefetched instruction holds a read
    input  wire        pf_dsp_i,        // Prefetched read is dual-operand DSP
    input  wire [2:0]  pf_xr_mode_i,    // X read addressing mode
    input  wire [15:0] pf_xr_ptr_i,     // X read pointer value
    input  wire [3:0]  pf_xr_reg_i,     // X read pointer number
    input  wire [15:0] pf_xr_lit_i,     // X read absolute address
    input  wire        pf_y_valid_i,    // Prefetched DSP Y read present
    input  wire [2:0]  pf_y_mode_i,     // Y read addressing mode
    input  wire [15:0] pf_y_ptr_i,      // Y read pointer value
    input  wire [3:0]  pf_y_reg_i,      // Y read pointer number
    input  wire        wr_valid_i,      // Current instruction writes
    input  wire [2:0]  wr_mode_i,       // X write addressing mode
    input  wire [15:0] wr_ptr_i,        // X write pointer value
    input  wire [15:0] wr_lit_i,        // Absolute address or reverse modifier
    input  wire [15:0] wr_data_i,       // Data to write
    input  wire        x_circ_en_i,     // X circular buffer enable
    input  wire [15:0] x_circ_lo_i,     // X circular start
    input  wire [15:0] x_circ_hi_i,     // X circular end
    input  wire        y_circ_en_i,     // Y circular buffer enable
    input  wire [15:0] y_circ_lo_i,     // Y circular start
    input  wire [15:0] y_circ_hi_i,     // Y circular end
    input  wire [15:0] xmem_rdata_i,    // Raw combined-space read data
    input  wire [15:0] ymem_rdata_i,    // Raw Y memory read data
    output reg  [15:0] xr_addr_o,       // X read address bus
    output reg         xr_en_o,         // X read strobe
    output reg  [15:0] xr_ptr_next_o,   // X read pointer update
    output reg  [15:0] y_addr_o,        // Y read address bus
    output reg         y_en_o,          // Y read strobe
    output reg  [15:0] y_ptr_next_o,    // Y pointer update
    output reg  [15:0] xw_addr_o,       // X write address bus
    output reg  [15:0] xw_data_o,       // X write data bus
    output reg         xw_en_o,         // X write strobe
    output reg  [15:0] xw_ptr_next_o,   // X write pointer update
    output reg  [15:0] x_rdata_o,       // Gated X read data
    output reg  [15:0] y_rdata_o,       // Gated Y read data
    output reg         addr_trap_o      // Address error trap pulse
);

    // ----------------------------------------
    // Pointer register numbers
    // ----------------------------------------
    localparam [3:0] X_OPERAND_POINTER_A = 4'h8;
    localparam [3:0] X_OPERAND_POINTER_B = 4'h9;
    localparam [3:0] Y_OPERAND_POINTER_A = 4'hA;
    localparam [3:0] Y_OPERAND_POINTER_B = 4'hB;

    function post_mode;
        input [2:0] m;
        begin
            post_mode = (m == `AM_INDIRECT) || (m == `AM_POST_INC) || (m == `AM_POST_DEC);
        end
    endfunction

    // ----------------------------------------
    // Address calculation
    // ----------------------------------------
    wire [15:0] xr_ea;
    wire [15:0] xr_pn;
    wire [15:0] y_ea;
    wire [15:0] y_pn;
    wire [15:0] xw_ea;
    wire [15:0] xw_pn;

    // circular on X read, no bit-reverse
    ea_calc u_xr_calc (
        .mode_i      (pf_xr_mode_i),
        .ptr_i       (pf_xr_ptr_i),
        .lit_i       (pf_xr_lit_i),
        .circ_en_i   (x_circ_en_i),
        .bitrev_ok_i (1'b0),
        .circ_lo_i   (x_circ_lo_i),
        .circ_hi_i   (x_circ_hi_i),
        .ea_o        (xr_ea),
        .ptr_next_o  (xr_pn)
    );

    ea_calc u_y_calc (
        .mode_i      (pf_y_mode_i),
        .ptr_i       (pf_y_ptr_i),
        .lit_i       (16'h0000),
        .circ_en_i   (y_circ_en_i),
        .bitrev_ok_i (1'b0),
        .circ_lo_i   (y_circ_lo_i),
        .circ_hi_i   (y_circ_hi_i),
        .ea_o        (y_ea),
        .ptr_next_o  (y_pn)
    );

    ea_calc u_xw_calc (
        .mode_i      (wr_mode_i),
        .ptr_i       (wr_ptr_i),
        .lit_i       (wr_lit_i),
        .circ_en_i   (x_circ_en_i),
        .bitrev_ok_i (1'b1),
        .circ_lo_i   (x_circ_lo_i),
        .circ_hi_i   (x_circ_hi_i),
        .ea_o        (xw_ea),
        .ptr_next_o  (xw_pn)
    );

    // ----------------------------------------
    // Region decode
    // ----------------------------------------
    wire xr_y;
    wire xr_unimpl;
    wire y_y;
    wire y_unimpl;
    wire xw_unimpl;

    space_decode #(.Y_BASE(Y_BASE), .RAM_END(RAM_END)) u_xr_dec (
        .ea_i      (xr_ea),
        .is_sfr_o  (),
        .is_x_o    (),
        .is_y_o    (xr_y),
        .is_near_o (),
        .unimpl_o  (xr_unimpl)
    );

    space_decode #(.Y_BASE(Y_BASE), .RAM_END(RAM_END)) u_y_dec (
        .ea_i      (y_ea),
        .is_sfr_o  (),
        .is_x_o    (),
        .is_y_o    (y_y),
        .is_near_o (),
        .unimpl_o  (y_unimpl)
    );

    space_decode #(.Y_BASE(Y_BASE), .RAM_END(RAM_END)) u_xw_dec (
        .ea_i      (xw_ea),
        .is_sfr_o  (),
        .is_x_o    (),
        .is_y_o    (),
        .is_near_o (),
        .unimpl_o  (xw_unimpl)
    );

    // ----------------------------------------
    // Request qualification
    // ----------------------------------------
    // DSP operand pointers are fixed registers
    wire xr_reg_ok = (pf_xr_reg_i == X_OPERAND_POINTER_A) || (pf_xr_reg_i == X_OPERAND_POINTER_B);
    wire y_reg_ok  = (pf_y_reg_i == Y_OPERAND_POINTER_A) || (pf_y_reg_i == Y_OPERAND_POINTER_B);
    // Y read only for DSP indirect or post-modify requests
    wire y_req     = pf_valid_i && pf_dsp_i && pf_y_valid_i && y_reg_ok && post_mode(pf_y_mode_i);
    // general reads take any pointer over the X unit
    wire xr_req    = pf_valid_i && (!pf_dsp_i || xr_reg_ok);

    // ----------------------------------------
    // Instruction cycle phase
    // ----------------------------------------
    reg  [1:0]  phase;
    reg  [15:0] xw_ea_hold;
    reg  [15:0] xw_data_hold;
    reg         xw_pending;
    reg         xw_bad;
    reg         xr_zero;
    reg         y_zero;
    reg         xr_live;
    reg         y_live;

    // read and write halves run in separate phases
    always @(posedge mclk_i) begin
        if (!nrst_i)
            phase <= `PH_READ;
        else if (cycle_start_i)
            phase <= `PH_EXEC;
        else if (phase == `PH_EXEC)
            phase <= `PH_WRITE;
        else if (phase == `PH_WRITE)
            phase <= `PH_LAST;
        else
            phase <= phase;
    end

    // ----------------------------------------
    // Read units
    // ----------------------------------------
    // addresses computed from prefetch, driven at cycle start
    always @(posedge mclk_i) begin
        if (!nrst_i) begin
            xr_addr_o     <= 16'h0000;
            xr_en_o       <= 1'b0;
            xr_ptr_next_o <= 16'h0000;
            y_addr_o      <= 16'h0000;
            y_en_o        <= 1'b0;
            y_ptr_next_o  <= 16'h0000;
            xr_zero       <= 1'b0;
            y_zero        <= 1'b0;
            xr_live       <= 1'b0;
            y_live        <= 1'b0;
        end else if (cycle_start_i) begin
            xr_addr_o     <= xr_ea;
            xr_ptr_next_o <= xr_pn;
            xr_en_o       <= xr_req && !xr_unimpl;
            // DSP X read into Y returns zero
            xr_zero       <= xr_unimpl || (pf_dsp_i && xr_y);
            xr_live       <= xr_req;
            y_addr_o      <= y_ea;
            y_ptr_next_o  <= y_pn;
            // Strobe only inside Y memory; X, register space and absent memory read as zero
            y_en_o        <= y_req && y_y;
            // DSP Y read into X returns zero
            y_zero        <= !y_y;
            y_live        <= y_req;
        end else begin
            xr_en_o <= 1'b0;
            y_en_o  <= 1'b0;
        end
    end

    // X read bus carries both combined and DSP X data
    always @(posedge mclk_i) begin
        if (!nrst_i) begin
            x_rdata_o <= 16'h0000;
            y_rdata_o <= 16'h0000;
        end else if (phase == `PH_EXEC) begin
            x_rdata_o <= (xr_live && !xr_zero) ? xmem_rdata_i : 16'h0000;
            y_rdata_o <= (y_live && !y_zero) ? ymem_rdata_i : 16'h0000;
        end
    end

    // ----------------------------------------
    // Write unit
    // ----------------------------------------
    // write address starts at cycle start, driven in write phase
    always @(posedge mclk_i) begin
        if (!nrst_i) begin
            xw_ea_hold    <= 16'h0000;
            xw_data_hold  <= 16'h0000;
            xw_pending    <= 1'b0;
            xw_bad        <= 1'b0;
            xw_ptr_next_o <= 16'h0000;
        end else if (cycle_start_i) begin
            xw_ea_hold    <= xw_ea;
            xw_data_hold  <= wr_data_i;
            xw_pending    <= wr_valid_i;
            xw_bad        <= wr_valid_i && xw_unimpl;
            xw_ptr_next_o <= xw_pn;
        end else if (phase == `PH_WRITE) begin
            xw_pending <= 1'b0;
            xw_bad     <= 1'b0;
        end
    end

    // every write, DSP or not, leaves on the X bus
    always @(posedge mclk_i) begin
        if (!nrst_i) begin
            xw_addr_o <= 16'h0000;
            xw_data_o <= 16'h0000;
            xw_en_o   <= 1'b0;
        end else if (phase == `PH_WRITE && xw_pending) begin
            xw_addr_o <= xw_ea_hold;
            xw_data_o <= xw_data_hold;
            // writes to absent memory are dropped
            xw_en_o   <= !xw_bad;
        end else begin
            xw_en_o <= 1'b0;
        end
    end

    // ----------------------------------------
    // Address error trap
    // ----------------------------------------
    // one pulse for a faulting read at cycle start, another for a faulting write in write phase
    always @(posedge mclk_i) begin
        if (!nrst_i)
            addr_trap_o <= 1'b0;
        else if (cycle_start_i)
            addr_trap_o <= (xr_req && xr_unimpl) || (y_req && y_unimpl);
        else if (phase == `PH_WRITE)
            addr_trap_o <= xw_pending && xw_bad;
        else
            addr_trap_o <= 1'b0;
    end

endmodule

/* File: testbench/data_memory_model.sv */
// Behavioural data memory answering the X read and Y read buses
`timescale 1ns/1ns

module data_memory_model (
    input  wire [15:0] xr_addr_i,    // X read address
    input  wire        xr_en_i,      // X read strobe
    input  wire [15:0] y_addr_i,     // Y read address
    input  wire        y_en_i,       // Y read strobe
    output wire [15:0] xmem_rdata_o, // Combined space data
    output wire [15:0] ymem_rdata_o  // Y memory data
);
    // whole words
    // Idle buses show the inverse so stale data can never pass as valid
    assign xmem_rdata_o = xr_en_i ? (xr_addr_i ^ 16'h5A3C) : ~(xr_addr_i ^ 16'h5A3C);
    assign ymem_rdata_o = y_en_i ? (y_addr_i ^ 16'hC3A5) : ~(y_addr_i ^ 16'hC3A5);
endmodule

/* File: testbench/agu_checker_assertions.sv */
// Port level checker for the data space address generation block
`timescale 1ns/1ns

module agu_checker #(
    parameter [15:0] Y_BASE  = 16'h0C00,
    parameter [15:0] RAM_END = 16'h0FFF
) (
    input wire        mclk_i,        // Clock
    input wire        nrst_i,        // Reset
    input wire        cycle_start_i, // Cycle open
    input wire        pf_valid_i,    // Read present
    input wire        pf_dsp_i,      // DSP read
    input wire [3:0]  pf_xr_reg_i,   // X pointer
    input wire        pf_y_valid_i,  // Y read
    input wire [2:0]  pf_y_mode_i,   // Y mode
    input wire [15:0] wr_data_i,     // Write data
    input wire [15:0] ymem_rdata_i,  // Y memory data
    input wire [15:0] xr_addr_o,     // X read addr
    input wire        xr_en_o,       // X read strobe
    input wire [15:0] y_addr_o,      // Y addr
    input wire        y_en_o,        // Y strobe
    input wire [15:0] xw_addr_o,     // Write addr
    input wire [15:0] xw_data_o,     // Write data
    input wire        xw_en_o,       // Write strobe
    input wire [15:0] y_rdata_o,     // Y data
    input wire        addr_trap_o    // Trap
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);

    sequence s_bad_x;
        cycle_start_i && pf_valid_i && pf_dsp_i && pf_xr_reg_i[3:1] != 3'h4;
    endsequence
    sequence s_bad_ymode;
        cycle_start_i && pf_y_valid_i && (pf_y_mode_i == 3'h0 || pf_y_mode_i > 3'h3);
    endsequence
    sequence s_y_refused;
        cycle_start_i && pf_valid_i && pf_dsp_i && pf_y_valid_i ##1 !y_en_o;
    endsequence

    a_read_timing: assert property (xr_en_o |-> $past(cycle_start_i))
        else $error("X read strobe out of phase");
    a_y_timing: assert property (y_en_o |-> $past(cycle_start_i))
        else $error("Y strobe out of phase");
    a_write_phase: assert property (xw_en_o |-> $past(cycle_start_i, 3) && xw_data_o == $past(wr_data_i, 3))
        else $error("Write not in write phase");
    a_xr_range: assert property (xr_en_o |-> xr_addr_o <= RAM_END)
        else $error("X read beyond memory");
    a_y_region: assert property (y_en_o |-> y_addr_o >= Y_BASE && y_addr_o <= RAM_END)
        else $error("Y read outside Y memory");
    a_xw_range: assert property (xw_en_o |-> xw_addr_o <= RAM_END)
        else $error("Write beyond memory kept");
    a_trap_origin: assert property (addr_trap_o |-> $past(cycle_start_i) || $past(cycle_start_i, 3))
        else $error("Trap at wrong moment");
    a_y_zero_data: assert property (s_y_refused |=> y_rdata_o == 16'h0000)
        else $error("Refused Y read gave data");
    a_y_pass_data: assert property (y_en_o |=> y_rdata_o == $past(ymem_rdata_i))
        else $error("Y data not passed");
    a_x_ptr_refuse: assert property (s_bad_x |-> ##1 !xr_en_o)
        else $error("DSP X read with wrong pointer");
    a_y_mode_refuse: assert property (s_bad_ymode |-> ##1 !y_en_o)
        else $error("Y read in unsupported mode");
endmodule

bind data_space_agu agu_checker #(.Y_BASE(Y_BASE), .RAM_END(RAM_END)) chk (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .cycle_start_i(cycle_start_i), .pf_valid_i(pf_valid_i),
    .pf_dsp_i(pf_dsp_i), .pf_xr_reg_i(pf_xr_reg_i), .pf_y_valid_i(pf_y_valid_i),
    .pf_y_mode_i(pf_y_mode_i), .wr_data_i(wr_data_i), .ymem_rdata_i(ymem_rdata_i),
    .xr_addr_o(xr_addr_o), .xr_en_o(xr_en_o), .y_addr_o(y_addr_o), .y_en_o(y_en_o),
    .xw_addr_o(xw_addr_o), .xw_data_o(xw_data_o), .xw_en_o(xw_en_o), .y_rdata_o(y_rdata_o),
    .addr_trap_o(addr_trap_o));

/* File: testbench/tb_data_space_agu.sv */
// Self-checking bench for the data space address generation block
`timescale 1ns/1ns

module tb_data_space_agu;
    localparam [15:0] YB = 16'h0C00;
    localparam [15:0] RE = 16'h0FFF;
    reg mclk_i = 0, nrst_i = 0, cycle_start_i = 0, pf_valid_i = 0, pf_dsp_i = 0, pf_y_valid_i = 0;
    reg wr_valid_i = 0, x_circ_en_i = 0, y_circ_en_i = 0;
    reg [2:0] pf_xr_mode_i = 0, pf_y_mode_i = 0, wr_mode_i = 0;
    reg [3:0] pf_xr_reg_i = 0, pf_y_reg_i = 0;
    reg [15:0] pf_xr_ptr_i = 0, pf_xr_lit_i = 0, pf_y_ptr_i = 0, wr_ptr_i = 0, wr_lit_i = 0, wr_data_i = 0;
    reg [15:0] x_circ_lo_i = 0, x_circ_hi_i = 0, y_circ_lo_i = 0, y_circ_hi_i = 0;
    wire [15:0] xmem_rdata_i, ymem_rdata_i, xr_addr_o, xr_ptr_next_o, y_addr_o, y_ptr_next_o;
    wire [15:0] xw_addr_o, xw_data_o, xw_ptr_next_o, x_rdata_o, y_rdata_o;
    wire xr_en_o, y_en_o, xw_en_o, addr_trap_o;
    int error_cnt = 0, comparisons = 0;

    data_space_agu #(.Y_BASE(YB), .RAM_END(RE)) dut (.*);
    data_memory_model mem (.xr_addr_i(xr_addr_o), .xr_en_i(xr_en_o), .y_addr_i(y_addr_o), .y_en_i(y_en_o),
                           .xmem_rdata_o(xmem_rdata_i), .ymem_rdata_o(ymem_rdata_i));

    initial begin
        forever #20 mclk_i = ~mclk_i;
    end

    // ----------------------------------------
    // Expectation helpers
    // ----------------------------------------
    function [15:0] ea(input [2:0] m, input [15:0] p, input [15:0] l);
        case (m)
            3'h0: ea = l;
            3'h4: ea = p + 16'h0002;
            3'h5: ea = p - 16'h0002;
            3'h6: ea = {3'h0, l[12:0]};
            default: ea = p;
        endcase
    endfunction
    function [15:0] nxt(input [2:0] m, input [15:0] p, input c, input [15:0] lo, input [15:0] hi);
        reg up, dn;
        begin
            up = m == 3'h2 || m == 3'h4 || m == 3'h7;
            dn = m == 3'h3 || m == 3'h5;
            nxt = up ? p + 16'h0002 : dn ? p - 16'h0002 : p;
            if (c && up && nxt > hi) nxt = lo;
            if (c && dn && nxt < lo) nxt = {hi[15:1], 1'b0};
        end
    endfunction
    function pm(input [2:0] m);
        pm = m != 3'h0 && m != 3'h1 && m != 3'h6;
    endfunction

    task check(input [15:0] seen, input [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task wrap_up;
        $display("Mismatches %0d of %0d comparisons", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task rst;
        nrst_i = 0;
        repeat (3) @(posedge mclk_i);
        #1 nrst_i = 1;
        check({xr_en_o, y_en_o, xw_en_o, addr_trap_o}, 16'h0000);
        check(x_rdata_o | y_rdata_o | xr_addr_o | xw_addr_o, 16'h0000);
    endtask

    task rd(input d, input [2:0] m, input [3:0] r, input [15:0] p, input [15:0] l);
        pf_valid_i = 1;
        pf_dsp_i = d;
        pf_xr_mode_i = m;
        pf_xr_reg_i = r;
        pf_xr_ptr_i = p;
        pf_xr_lit_i = l;
        pf_y_valid_i = 0;
        wr_valid_i = 0;
    endtask
    task yq(input [2:0] m, input [3:0] r, input [15:0] p);
        pf_y_valid_i = 1;
        pf_y_mode_i = m;
        pf_y_reg_i = r;
        pf_y_ptr_i = p;
    endtask
    task wq(input [2:0] m, input [15:0] p, input [15:0] l);
        wr_valid_i = 1;
        wr_mode_i = m;
        wr_ptr_i = p;
        wr_lit_i = l;
        wr_data_i = p ^ l ^ 16'h1357;
    endtask

    // One instruction cycle: open at E, check E, E+1, E+2, E+3
    task op;
        reg [15:0] xa, wa;
        reg xok, xbad, yon, ybad, yen, wbad, wok;
        begin
            xok = pf_valid_i && !(pf_dsp_i && pf_xr_reg_i[3:1] != 3'h4);
            xa = ea(pf_xr_mode_i, pf_xr_ptr_i, pf_xr_lit_i);
            xbad = xok && xa > RE;
            xok = xok && !xbad;
            yon = pf_valid_i && pf_dsp_i && pf_y_valid_i && pf_y_reg_i[3:1] == 3'h5;
            yon = yon && pf_y_mode_i >= 3'h1 && pf_y_mode_i <= 3'h3;
            ybad = yon && pf_y_ptr_i > RE;
            yen = yon && !ybad && pf_y_ptr_i >= YB;
            wa = ea(wr_mode_i, wr_ptr_i, wr_lit_i);
            wbad = wr_valid_i && wa > RE;
            wok = wr_valid_i && !wbad;
            cycle_start_i = 1;
            @(posedge mclk_i) #1 cycle_start_i = 0;
            check(xr_en_o, xok);
            if (xok) check(xr_addr_o, xa);
            if (xok && pm(pf_xr_mode_i)) check(xr_ptr_next_o, nxt(pf_xr_mode_i, pf_xr_ptr_i, x_circ_en_i, x_circ_lo_i, x_circ_hi_i));
            check(y_en_o, yen);
            if (yen) check(y_addr_o, pf_y_ptr_i);
            if (yen) check(y_ptr_next_o, nxt(pf_y_mode_i, pf_y_ptr_i, y_circ_en_i, y_circ_lo_i, y_circ_hi_i));
            check(addr_trap_o, xbad || ybad);
            @(posedge mclk_i) #1;
            if (pf_valid_i) check(x_rdata_o, (xok && !(pf_dsp_i && xa >= YB)) ? xa ^ 16'h5A3C : 16'h0000);
            if (pf_valid_i && pf_dsp_i && pf_y_valid_i) check(y_rdata_o, yen ? pf_y_ptr_i ^ 16'hC3A5 : 16'h0000);
            check(xr_en_o | addr_trap_o, 16'h0000);
            @(posedge mclk_i) #1;
            check(xw_en_o, wok);
            if (wok && wr_mode_i != 3'h7) check(xw_addr_o, wa);
            if (wok) check(xw_data_o, wr_data_i);
            if (wok && pm(wr_mode_i) && wr_mode_i != 3'h7) check(xw_ptr_next_o, nxt(wr_mode_i, wr_ptr_i, x_circ_en_i, x_circ_lo_i, x_circ_hi_i));
            check(addr_trap_o, wbad);
            @(posedge mclk_i) #1;
            check(xw_en_o, 16'h0000);
        end
    endtask

    initial begin
        void'($urandom(87250));
        rst;
        rd(0, 3'h1, 4'h3, 16'h0C10, 0); op;
        rd(0, 3'h0, 4'h0, 0, 16'h0010); op;
        rd(0, 3'h6, 4'h0, 0, 16'hEA00); op;
        rd(0, 3'h6, 4'h0, 0, 16'h1ABC); op;
        rd(0, 3'h0, 4'h0, 0, 16'hFFFE); op;
        rd(1, 3'h2, 4'h8, 16'h0D00, 0); yq(3'h2, 4'hA, 16'h0C40); op;
        rd(1, 3'h1, 4'h5, 16'h0900, 0); yq(3'h3, 4'hB, 16'h0900); op;
        rd(1, 3'h1, 4'h9, 16'h1000, 0); yq(3'h1, 4'hA, 16'h2000); op;
        rd(1, 3'h7, 4'h9, 16'h0A00, 0); yq(3'h4, 4'hA, 16'h0C00); wq(3'h7, 16'h0A00, 16'h0010); op;
        rd(1, 3'h1, 4'h8, 16'h0800, 0); yq(3'h1, 4'hC, 16'h0C02); wq(3'h2, 16'h0C20, 0); op;
        wq(3'h0, 0, 16'h1000); op;
        x_circ_en_i = 1; x_circ_lo_i = 16'h0900; x_circ_hi_i = 16'h090F;
        y_circ_en_i = 1; y_circ_lo_i = 16'h0C00; y_circ_hi_i = 16'h0C0F;
        rd(1, 3'h2, 4'h8, 16'h090E, 0); yq(3'h3, 4'hB, 16'h0C00); wq(3'h3, 16'h0900, 0); op;
        x_circ_en_i = 0; y_circ_en_i = 0;
        rst;
        repeat (300) begin
            rd($urandom % 2, 3'($urandom % 8), 4'($urandom % 16), 16'($urandom % 16'h1400), 16'($urandom));
            if (pf_dsp_i && $urandom % 4 != 0) pf_xr_reg_i = 4'h8 + 4'($urandom % 2);
            if (pf_dsp_i) yq(3'($urandom % 5), 4'h9 + 4'($urandom % 4), 16'($urandom % 16'h1400) & 16'hFFFE);
            if ($urandom % 2) wq(3'($urandom % 7), 16'($urandom % 16'h1400), 16'($urandom % 16'h1400));
            op;
        end
        wrap_up;
    end
endmodule
